// ---- pkg/gpx_regs.svh ----
// Register offsets, field positions, reset values and bus timing for the GPIO expander
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (pointer values on the serial bus)
// ----------------------------------------------------------------
`define GPX_OFS_CTRL     8'h00
`define GPX_OFS_DIR      8'h01
`define GPX_OFS_OUT      8'h02
`define GPX_OFS_IN       8'h03
`define GPX_OFS_PULL_EN  8'h04
`define GPX_OFS_PULL_SEL 8'h05
`define GPX_OFS_DFLT     8'h06
`define GPX_OFS_MASK     8'h07
`define GPX_OFS_STAT     8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GPX_CTRL_SWRST   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPX_RST_DIR      8'h00
`define GPX_RST_OUT      8'h00
`define GPX_RST_PULL_EN  8'h00
`define GPX_RST_PULL_SEL 8'h00
`define GPX_RST_DFLT     8'h00
`define GPX_RST_MASK     8'hFF
`define GPX_RST_STAT     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPX_CLK_HZ       20000000
`define GPX_SCL_MAX_HZ   1000000
`define GPX_SCL_CYCLES   (`GPX_CLK_HZ / `GPX_SCL_MAX_HZ)

`endif

// ---- pkg/gpx_pkg.sv ----
// Types shared by the GPIO expander modules
package gpx_pkg;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_ACKA  = 8'h04,
    ST_WR    = 8'h08,
    ST_ACKW  = 8'h10,
    ST_RD    = 8'h20,
    ST_RDACK = 8'h40,
    ST_RDLD  = 8'h80
  } gpx_state_t;

endpackage

// ---- hdl/gpx_gpio_port.sv ----
// Per-line pad control, input sampling and mismatch detection
`timescale 1ns/1ps
`include "gpx_regs.svh"

module gpx_gpio_port import gpx_pkg::*; #(
  parameter int LINES = 8
) (
  input  wire logic             core_clk_i,  // System clock
  input  wire logic             reg_rst_i,   // Register reset, active high
  input  wire logic [LINES-1:0] pins_i,      // Line levels
  input  wire logic [LINES-1:0] dir_i,       // 1 = output
  input  wire logic [LINES-1:0] out_i,       // Output data
  input  wire logic [LINES-1:0] pull_en_i,   // Pull enable
  input  wire logic [LINES-1:0] pull_sel_i,  // 1 = pull-up
  input  wire logic [LINES-1:0] dflt_i,      // Default state
  input  wire logic [LINES-1:0] mask_i,      // 1 = masked
  output logic      [LINES-1:0] in_o,        // Sampled input data
  output logic      [LINES-1:0] pins_o,      // Driven level
  output logic      [LINES-1:0] pins_oe_o,   // Driver enable
  output logic      [LINES-1:0] pull_up_o,   // Pull-up enable
  output logic      [LINES-1:0] pull_dn_o,   // Pull-down enable
  output logic      [LINES-1:0] mism_o       // Unmasked input mismatch
);

  logic [LINES-1:0] in_reg;

  always_ff @(posedge core_clk_i) begin
    if (reg_rst_i) begin
      in_reg <= '0;
    end else begin
      in_reg <= pins_i;
    end
  end

  assign in_o = in_reg;

  // ----------------------------------------------------------------
  // Per-line logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < LINES; i++) begin : g_line
    assign pins_oe_o[i] = dir_i[i];
    assign pins_o[i]    = out_i[i];
    assign pull_up_o[i] = ~dir_i[i] & pull_en_i[i] & pull_sel_i[i];
    assign pull_dn_o[i] = ~dir_i[i] & pull_en_i[i] & ~pull_sel_i[i];
    assign mism_o[i]    = ~dir_i[i] & ~mask_i[i] & (in_reg[i] ^ dflt_i[i]);
  end

endmodule // gpx_gpio_port

// ---- hdl/gpx_expander.sv ----
// Eight-line GPIO expander with serial slave register access
// Functional notes
// - All lines inputs, drivers off after reset
// - Direction bits set each line input or output
// - Input and output data registers, bit per line
// - Every register but CTRL reads back its current contents; CTRL reads 00
// - Interrupt low when input differs from default, until status is read
// - Per-line mask blocks interrupt for that line
// - Interrupt open-drain, only pulls low or releases
// - Per-line pull-up or pull-down for inputs
// - Low hardware reset returns to power-on state
// - Address pin selects one of two addresses
// - Serial bus up to 1MHz clock rate
// - Outputs drive high and low, push-pull
`timescale 1ns/1ps
`include "gpx_regs.svh"

module gpx_expander import gpx_pkg::*; #(
  parameter logic [5:0] ADDR_BASE = 6'h10  // Upper address bits, plain default
) (
  input  wire logic       core_clk_i,      // System clock, 20 MHz
  input  wire logic       rst_i,           // Synchronous reset, active high
  input  wire logic       hw_reset_n_i,    // Hardware reset pin, active low
  input  wire logic       addr_sel_i,      // Address select strap
  input  wire logic       scl_i,           // Serial clock
  input  wire logic       sda_i,           // Serial data level
  output logic            sda_o,           // Serial data drive value
  output logic            sda_oe_o,        // Serial data pull-low enable
  output logic            int_n_o,         // Interrupt drive value
  output logic            int_n_oe_o,      // Interrupt pull-low enable
  input  wire logic [7:0] gpio_lines_i,    // Line levels
  output logic      [7:0] gpio_lines_o,    // Line drive values
  output logic      [7:0] gpio_lines_oe_o, // Line driver enables
  output logic      [7:0] pull_up_o,       // Pull-up enables
  output logic      [7:0] pull_dn_o        // Pull-down enables
);

  // ----------------------------------------------------------------
  // Resets and address strap
  // ----------------------------------------------------------------
  logic       fsm_rst;
  logic       reg_rst;
  logic       swrst_reg;
  logic       addr_sel_reg;
  logic [6:0] my_addr;

  assign fsm_rst = rst_i | ~hw_reset_n_i;
  assign reg_rst = fsm_rst | swrst_reg;
  assign my_addr = {ADDR_BASE, addr_sel_reg};

  // Strap is caught while reset is held
  always_ff @(posedge core_clk_i) begin
    if (fsm_rst) begin
      addr_sel_reg <= addr_sel_i;
    end
  end

  // ----------------------------------------------------------------
  // Bus sampling
  // ----------------------------------------------------------------
  logic scl_reg;
  logic scl_prev;
  logic sda_reg;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge core_clk_i) begin
    if (fsm_rst) begin
      scl_reg  <= 1'b1;
      scl_prev <= 1'b1;
      sda_reg  <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_reg  <= scl_i;
      scl_prev <= scl_reg;
      sda_reg  <= sda_i;
      sda_prev <= sda_reg;
    end
  end

  // 20 clocks per bit at 1MHz leave room for edge detection
  assign scl_rise  = scl_reg & ~scl_prev;
  assign scl_fall  = ~scl_reg & scl_prev;
  assign bus_start = scl_reg & scl_prev & sda_prev & ~sda_reg;
  assign bus_stop  = scl_reg & scl_prev & ~sda_prev & sda_reg;

  // ----------------------------------------------------------------
  // Slave state machine
  // ----------------------------------------------------------------
  gpx_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic       ptr_phase_reg;
  logic       rw_reg;
  logic       oe_reg;
  logic [7:0] byte_in;
  logic       last_bit;
  logic       addr_hit;
  logic       wr_fire;
  logic       rd_load;
  logic [7:0] rd_data;

  assign byte_in  = {shift_reg[6:0], sda_reg};
  assign last_bit = (bit_cnt_reg == 3'h7);
  assign addr_hit = (byte_in[7:1] == my_addr);
  assign wr_fire  = (state_reg == ST_WR) & scl_rise & last_bit & ~ptr_phase_reg;
  assign rd_load  = scl_fall & (((state_reg == ST_ACKA) & oe_reg & rw_reg) | (state_reg == ST_RDLD));

  always_ff @(posedge core_clk_i) begin
    if (fsm_rst) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      ptr_phase_reg <= 1'b0;
      rw_reg        <= 1'b0;
      oe_reg        <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= ST_IDLE;
      oe_reg    <= 1'b0;
    end else if (bus_start) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      oe_reg      <= 1'b0;
    end else if (rd_load) begin
      state_reg   <= ST_RD;
      shift_reg   <= {rd_data[6:0], 1'b0};
      oe_reg      <= ~rd_data[7];
      bit_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          oe_reg <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (last_bit) begin
              state_reg     <= addr_hit ? ST_ACKA : ST_IDLE;
              rw_reg        <= sda_reg;
              ptr_phase_reg <= ~sda_reg;
            end
          end
        end
        ST_ACKA, ST_ACKW: begin
          if (scl_fall) begin
            if (!oe_reg) begin
              oe_reg <= 1'b1;
            end else begin
              oe_reg      <= 1'b0;
              state_reg   <= ST_WR;
              bit_cnt_reg <= 3'h0;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (last_bit) begin
              state_reg     <= ST_ACKW;
              ptr_phase_reg <= 1'b0;
              ptr_reg       <= ptr_phase_reg ? byte_in : ptr_reg + 8'h01;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (last_bit) begin
              state_reg <= ST_RDACK;
              ptr_reg   <= ptr_reg + 8'h01;
            end
          end else if (scl_fall) begin
            oe_reg    <= ~shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        ST_RDACK: begin
          if (scl_fall) begin
            oe_reg <= 1'b0;
          end else if (scl_rise) begin
            state_reg <= sda_reg ? ST_IDLE : ST_RDLD;
          end
        end
        ST_RDLD: begin
          oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] dir_reg;
  logic [7:0] out_reg;
  logic [7:0] pull_en_reg;
  logic [7:0] pull_sel_reg;
  logic [7:0] dflt_reg;
  logic [7:0] mask_reg;
  logic [7:0] stat_reg;
  logic [7:0] mism_prev_reg;
  logic       ack_reg;
  logic [7:0] in_data;
  logic [7:0] mism;
  logic [7:0] mism_new;
  logic       stat_read;
  logic       wr_dir;
  logic       wr_out;
  logic       wr_pull_en;
  logic       wr_pull_sel;
  logic       wr_dflt;
  logic       wr_mask;
  logic       wr_swrst;

  assign wr_dir      = wr_fire & (ptr_reg == `GPX_OFS_DIR);
  assign wr_out      = wr_fire & (ptr_reg == `GPX_OFS_OUT);
  assign wr_pull_en  = wr_fire & (ptr_reg == `GPX_OFS_PULL_EN);
  assign wr_pull_sel = wr_fire & (ptr_reg == `GPX_OFS_PULL_SEL);
  assign wr_dflt     = wr_fire & (ptr_reg == `GPX_OFS_DFLT);
  assign wr_mask     = wr_fire & (ptr_reg == `GPX_OFS_MASK);
  assign wr_swrst    = wr_fire & (ptr_reg == `GPX_OFS_CTRL) & byte_in[`GPX_CTRL_SWRST];
  assign stat_read   = rd_load & (ptr_reg == `GPX_OFS_STAT);
  assign mism_new    = mism & ~mism_prev_reg;

  // Read mux, every register but CTRL returns its live contents; CTRL and unmapped offsets read 00
  assign rd_data = (ptr_reg == `GPX_OFS_DIR)      ? dir_reg      :
                   (ptr_reg == `GPX_OFS_OUT)      ? out_reg      :
                   (ptr_reg == `GPX_OFS_IN)       ? in_data      :
                   (ptr_reg == `GPX_OFS_PULL_EN)  ? pull_en_reg  :
                   (ptr_reg == `GPX_OFS_PULL_SEL) ? pull_sel_reg :
                   (ptr_reg == `GPX_OFS_DFLT)     ? dflt_reg     :
                   (ptr_reg == `GPX_OFS_MASK)     ? mask_reg     :
                   (ptr_reg == `GPX_OFS_STAT)     ? stat_reg     : 8'h00;

  // Software reset takes effect one clock after the data byte
  always_ff @(posedge core_clk_i) begin
    if (fsm_rst) begin
      swrst_reg <= 1'b0;
    end else begin
      swrst_reg <= wr_swrst;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reg_rst) begin
      dir_reg      <= `GPX_RST_DIR;
      out_reg      <= `GPX_RST_OUT;
      pull_en_reg  <= `GPX_RST_PULL_EN;
      pull_sel_reg <= `GPX_RST_PULL_SEL;
      dflt_reg     <= `GPX_RST_DFLT;
      mask_reg     <= `GPX_RST_MASK;
    end else begin
      if (wr_dir)      dir_reg      <= byte_in;
      if (wr_out)      out_reg      <= byte_in;
      if (wr_pull_en)  pull_en_reg  <= byte_in;
      if (wr_pull_sel) pull_sel_reg <= byte_in;
      if (wr_dflt)     dflt_reg     <= byte_in;
      if (wr_mask)     mask_reg     <= byte_in;
    end
  end

  // Status bits are sticky; a new mismatch wins over the read clear
  always_ff @(posedge core_clk_i) begin
    if (reg_rst) begin
      stat_reg      <= `GPX_RST_STAT;
      mism_prev_reg <= 8'h00;
      ack_reg       <= 1'b0;
    end else begin
      mism_prev_reg <= mism;
      stat_reg      <= (stat_read ? 8'h00 : stat_reg) | mism;
      if (mism_new != 8'h00) begin
        ack_reg <= 1'b0;
      end else if (stat_read) begin
        ack_reg <= 1'b1;
      end
    end
  end

  // Pull low only while an unacknowledged mismatch stands
  assign int_n_o    = 1'b0;
  assign int_n_oe_o = (mism != 8'h00) & ~ack_reg;

  // ----------------------------------------------------------------
  // Line logic
  // ----------------------------------------------------------------
  gpx_gpio_port #(
    .LINES (8)
  ) u_port (
    .core_clk_i (core_clk_i),
    .reg_rst_i  (reg_rst),
    .pins_i     (gpio_lines_i),
    .dir_i      (dir_reg),
    .out_i      (out_reg),
    .pull_en_i  (pull_en_reg),
    .pull_sel_i (pull_sel_reg),
    .dflt_i     (dflt_reg),
    .mask_i     (mask_reg),
    .in_o       (in_data),
    .pins_o     (gpio_lines_o),
    .pins_oe_o  (gpio_lines_oe_o),
    .pull_up_o  (pull_up_o),
    .pull_dn_o  (pull_dn_o),
    .mism_o     (mism)
  );

endmodule // gpx_expander

// ---- verif/gpx_i2c_master.sv ----
// Serial bus master model that drives the expander's slave port
`timescale 1ns/1ps

module gpx_i2c_master (
  input  wire logic core_clk_i, // System clock
  input  wire logic sda_i,      // Resolved data wire
  output logic      scl_o,      // Serial clock, idle high
  output logic      low_o       // High pulls data wire low
);
  initial begin
    scl_o = 1'b1;
    low_o = 1'b0;
  end
  // Ten clocks each half period keeps the bus at 1 MHz
  task automatic half();
    repeat (10) @(negedge core_clk_i);
  endtask
  // Also serves as repeated start when entered with clock low
  task automatic start();
    low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    low_o = 1'b1;
    half();
    scl_o = 1'b0;
    half();
  endtask
  task automatic stop();
    low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    low_o = 1'b0;
    half();
  endtask
  // Data moves one clock after the fall so it never races the clock edge
  task automatic bit_x(input logic b, output logic r);
    low_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    r = sda_i;
    scl_o = 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule // gpx_i2c_master

// ---- verif/gpx_expander_properties.sv ----
// Port-level checks for the GPIO expander
`timescale 1ns/1ps

module gpx_expander_properties (
  input wire logic       core_clk_i,      // Clock
  input wire logic       rst_i,           // Reset
  input wire logic       hw_reset_n_i,    // Pin reset
  input wire logic       addr_sel_i,      // Strap
  input wire logic       scl_i,           // Clock wire
  input wire logic       sda_i,           // Data wire
  input wire logic       sda_o,           // Data value
  input wire logic       sda_oe_o,        // Data pull
  input wire logic       int_n_o,         // Int value
  input wire logic       int_n_oe_o,      // Int pull
  input wire logic [7:0] gpio_lines_i,    // Levels
  input wire logic [7:0] gpio_lines_o,    // Drive
  input wire logic [7:0] gpio_lines_oe_o, // Enables
  input wire logic [7:0] pull_up_o,       // Ups
  input wire logic [7:0] pull_dn_o        // Downs
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_int_od; int_n_o == 1'b0; endproperty
  a_int_od: assert property (p_int_od) else $error("interrupt driven high");
  property p_pull_one; (pull_up_o & pull_dn_o) == 8'h00; endproperty
  a_pull_one: assert property (p_pull_one) else $error("both pulls on");
  property p_pull_in; ((pull_up_o | pull_dn_o) & gpio_lines_oe_o) == 8'h00; endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull on output line");
  property p_rst_state; $fell(rst_i) |-> gpio_lines_oe_o == 8'h00 && !int_n_oe_o && !sda_oe_o; endproperty
  a_rst_state: assert property (p_rst_state) else $error("not idle after reset");
  property p_hw_rst; !hw_reset_n_i |=> gpio_lines_oe_o == 8'h00 && gpio_lines_o == 8'h00 && !int_n_oe_o; endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("pin reset ignored");
  property p_int_in; int_n_oe_o |-> gpio_lines_oe_o != 8'hFF || $past(gpio_lines_oe_o) != 8'hFF; endproperty
  a_int_in: assert property (p_int_in) else $error("interrupt with no input");
  property p_sda_lo; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_sda_lo: assert property (p_sda_lo) else $error("data moved with clock high");
  property p_cfg_hi;
    ($changed(gpio_lines_oe_o) || $changed(gpio_lines_o)) && hw_reset_n_i && $past(hw_reset_n_i) |-> scl_i;
  endproperty
  a_cfg_hi: assert property (p_cfg_hi) else $error("line setup moved off a data bit");
endmodule // gpx_expander_properties

// ---- verif/tb.sv ----
// Self-checking bench for the GPIO expander
`timescale 1ns/1ps
`include "gpx_regs.svh"

module tb import gpx_pkg::*;;
  logic       core_clk_i;
  logic       rst_i;
  logic       hw_reset_n_i;
  logic       addr_sel_i;
  logic       scl;
  logic       m_low;
  logic       sda_o;
  logic       sda_oe_o;
  logic       int_n_o;
  logic       int_n_oe_o;
  logic [7:0] gp_o;
  logic [7:0] gp_oe;
  logic [7:0] pu;
  logic [7:0] pd;
  logic [7:0] ext;
  logic [6:0] dev;
  int         error_cnt;
  int         compares;
  wire  logic       sda = ~(m_low | sda_oe_o);
  wire  logic [7:0] lvl = (gp_oe & gp_o) | (~gp_oe & ext);

  gpx_i2c_master i_master (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .low_o(m_low));
  gpx_expander i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i), .addr_sel_i(addr_sel_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
    .int_n_oe_o(int_n_oe_o), .gpio_lines_i(lvl), .gpio_lines_o(gp_o), .gpio_lines_oe_o(gp_oe),
    .pull_up_o(pu), .pull_dn_o(pd));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] o, input logic [7:0] d);
    logic a;
    i_master.start();
    i_master.wr({dev, 1'b0}, a);
    chk("addr ack", 8'h01, {7'h00, a});
    i_master.wr(o, a);
    i_master.wr(d, a);
    i_master.stop();
  endtask
  task automatic rd_chk(input string n, input logic [7:0] o, input logic [7:0] e);
    logic a;
    logic [7:0] d;
    i_master.start();
    i_master.wr({dev, 1'b0}, a);
    i_master.wr(o, a);
    i_master.start();
    i_master.wr({dev, 1'b1}, a);
    i_master.rd(1'b1, d);
    i_master.stop();
    chk(n, e, d);
  endtask
  task automatic t_reset();
    chk("oe", 8'h00, gp_oe);
    chk("pulls", 8'h00, pu | pd);
    chk("sda value", 8'h00, {7'h00, sda_o});
    rd_chk("dir", `GPX_OFS_DIR, `GPX_RST_DIR);
    rd_chk("mask", `GPX_OFS_MASK, `GPX_RST_MASK);
  endtask
  task automatic t_ports();
    ext = 8'h30;
    reg_wr(`GPX_OFS_DIR, 8'h0F);
    reg_wr(`GPX_OFS_OUT, 8'hA5);
    chk("oe", 8'h0F, gp_oe);
    chk("drive", 8'hA5, gp_o);
    rd_chk("in", `GPX_OFS_IN, 8'h35);
    rd_chk("out", `GPX_OFS_OUT, 8'hA5);
    reg_wr(`GPX_OFS_PULL_EN, 8'hFF);
    reg_wr(`GPX_OFS_PULL_SEL, 8'hC0);
    chk("up", 8'hC0, pu);
    chk("down", 8'h30, pd);
  endtask
  task automatic t_irq();
    reg_wr(`GPX_OFS_DFLT, 8'h00);
    reg_wr(`GPX_OFS_MASK, 8'hEF);
    chk("int", 8'h01, {7'h00, int_n_oe_o});
    chk("int value", 8'h00, {7'h00, int_n_o});
    ext = 8'h20;
    repeat (3) @(negedge core_clk_i);
    chk("int", 8'h00, {7'h00, int_n_oe_o});
    ext = 8'h30;
    repeat (3) @(negedge core_clk_i);
    chk("int", 8'h01, {7'h00, int_n_oe_o});
    // Line 4 now matches its default bit, so the request drops
    reg_wr(`GPX_OFS_DFLT, 8'h10);
    chk("int", 8'h00, {7'h00, int_n_oe_o});
    rd_chk("dflt", `GPX_OFS_DFLT, 8'h10);
    reg_wr(`GPX_OFS_DFLT, 8'h00);
    chk("int", 8'h01, {7'h00, int_n_oe_o});
    rd_chk("stat", `GPX_OFS_STAT, 8'h10);
    chk("int", 8'h00, {7'h00, int_n_oe_o});
  endtask
  task automatic t_swrst();
    reg_wr(`GPX_OFS_CTRL, 8'h01);
    chk("oe", 8'h00, gp_oe);
    chk("pulls", 8'h00, pu | pd);
    rd_chk("mask", `GPX_OFS_MASK, `GPX_RST_MASK);
    rd_chk("ctrl", `GPX_OFS_CTRL, 8'h00);
    rd_chk("unmapped", 8'h0A, 8'h00);
  endtask
  task automatic t_hwrst();
    logic a;
    reg_wr(`GPX_OFS_DIR, 8'hFF);
    chk("oe", 8'hFF, gp_oe);
    addr_sel_i = 1'b1;
    hw_reset_n_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    hw_reset_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("oe", 8'h00, gp_oe);
    i_master.start();
    i_master.wr({dev, 1'b0}, a);
    i_master.stop();
    chk("old addr ack", 8'h00, {7'h00, a});
    dev = 7'h21;
    rd_chk("dir", `GPX_OFS_DIR, `GPX_RST_DIR);
  endtask
  initial begin
    rst_i = 1'b1;
    hw_reset_n_i = 1'b1;
    addr_sel_i = 1'b0;
    ext = 8'h00;
    dev = 7'h20;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    t_reset();
    t_ports();
    t_irq();
    t_swrst();
    t_hwrst();
    end_of_test();
  end
  // Cuts a hung run short
  initial begin
    repeat (90000) @(negedge core_clk_i);
    error_cnt++;
    end_of_test();
  end
endmodule // tb

bind gpx_expander gpx_expander_properties i_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .hw_reset_n_i(hw_reset_n_i), .addr_sel_i(addr_sel_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
  .int_n_oe_o(int_n_oe_o), .gpio_lines_i(gpio_lines_i), .gpio_lines_o(gpio_lines_o),
  .gpio_lines_oe_o(gpio_lines_oe_o), .pull_up_o(pull_up_o), .pull_dn_o(pull_dn_o));
